// >>> cvg_core_model.sv
`timescale 1ns/1ps
module cvg_core_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ready,
	output logic valid,
	output cvg_pkg::cvg_frame_type data
);
	import cvg_pkg::*;
	cvg_frame_type pend[$]; // Frames still to hand over
	// Offer head frame, hold it while refused
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			valid <= 1'b0;
			data <= '0;
		end
		else if (valid && !ready)
		begin
			valid <= 1'b1;
		end
		else if (pend.size() != 0)
		begin
			valid <= 1'b1;
			data <= pend.pop_front();
		end
		else
		begin
			valid <= 1'b0;
			data <= ~data; // Released bus flips to the bitwise inverse of its value on every idle cycle
		end
	end
	task automatic push(input cvg_frame_type f);
		pend.push_back(f);
	endtask
endmodule

// >>> cvg_pkg.sv
package cvg_pkg;

	// Configuration register field positions
	localparam int CFG_MODE_LSB = 29;
	localparam int CFG_DEPTH_BIT = 28;
	localparam int CFG_BCAST_CHROMA_BIT = 27;
	localparam int CFG_BASE_CHROMA_BIT = 26;
	localparam int CFG_AURAL_LSB = 23;
	localparam int CFG_GROUP_LSB = 9;
	localparam int CFG_MASK_LSB = 0;

	// Writable bits; reserved bits always read as zero
	localparam logic [31:0] CFG_WRITE_MASK = 32'h7f80_0eff;

	// Scale register field positions
	localparam int SCL_PIXEL_LSB = 12;
	localparam int SCL_FRAME_LSB = 0;
	localparam logic [31:0] SCL_WRITE_MASK = 32'h000f_ffff;

	// Reset values of both registers
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] SCL_RESET = 32'h0000_0000;

	// Zero in a count field stands for the full range
	localparam logic [8:0] PIXEL_ZERO_COUNT = 9'h100;
	localparam logic [12:0] FRAME_ZERO_COUNT = 13'h1000;

	// Last pixel index for each colour depth
	localparam logic [4:0] LAST_IDX_TWO = 5'h1f;
	localparam logic [4:0] LAST_IDX_FOUR = 5'h0f;

	// Output mode encodings
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_PARALLEL = 2'h1;
	localparam logic [1:0] MODE_COMP_BCAST_HIGH = 2'h2;
	localparam logic [1:0] MODE_COMP_BCAST_LOW = 2'h3;

	// Highest legal pin group
	localparam logic [2:0] GROUP_LAST = 3'h3;

	// One frame handed over by the core
	typedef struct packed
	{
		logic [31:0] colours;
		logic [31:0] pixels;
	} cvg_frame_type;

endpackage

// >>> cvg_video_generator.sv
// Notes on behaviour
// - Mode field picks off, parallel, two composites
// - Depth bit: 32x1 or 16x2 pixels
// - Broadcast chroma enable bit gates broadcast colour
// - Baseband chroma enable bit gates baseband colour
// - Aural field picks one of eight PLL carriers
// - Group field routes to pins 0-31; 4-7 reserved
// - Mask gates each pin of the group
// - Pixel count field, zero means 256
// - Frame count field, zero means 4096
// - Each frame takes colour and pixel words
// - Pixels index colour bytes by depth
// - Pixels shift out least significant first
// - Last pixel repeats until frame count ends
// - No pending handoff: latch core buses anyway
// - Parallel mode puts colour byte on pins
// - Composite byte: luma, modulate flag, phase
// - Modulated luma swings plus/minus one at phase
// - Broadcast only with running second PLL
`timescale 1ns/1ps

module cvg_video_generator
#(
	parameter int DEPTH = 2
)
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CONFIG_WRITE,
	input wire logic SCALE_WRITE,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] CONFIG_RDATA,
	output logic [31:0] SCALE_RDATA,
	input wire logic HANDOFF_VALID,
	output logic HANDOFF_READY,
	input wire cvg_pkg::cvg_frame_type HANDOFF_DATA,
	input wire cvg_pkg::cvg_frame_type CORE_BUS_DATA,
	output logic FRAME_STARVED,
	input wire logic COUNTER_A_PLL_CLOCK,
	input wire logic COUNTER_B_PLL_CLOCK,
	input wire logic COUNTER_B_RUNNING,
	input wire logic [7:0] AURAL_PLL_CLOCKS,
	output logic [31:0] PIN_OUT,
	output logic [31:0] PIN_OE_N
);
	import cvg_pkg::*;

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	// Programmer-visible registers
	logic [31:0] video_configuration;
	logic [31:0] video_scale;

	// Field views of the registers
	logic [1:0] output_mode_field;
	logic colour_depth_bit;
	logic broadcast_chroma_enable;
	logic baseband_chroma_enable;
	logic [2:0] aural_source_select;
	logic [2:0] pin_group_select;
	logic [7:0] pin_output_mask;
	logic [7:0] clocks_per_pixel;
	logic [11:0] clocks_per_frame;

	// Synchronisers for the PLL clocks, which are foreign to CLK
	logic [10:0] sync_meta;
	logic [10:0] sync_stable;
	logic pll_a_prev;
	logic pll_a_tick;

	// Handoff buffer
	cvg_frame_type buffer_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] fill;
	logic buffer_push;
	logic buffer_pop;

	// Frame engine
	cvg_frame_type frame;
	logic [8:0] pixel_count;
	logic [12:0] frame_count;
	logic [4:0] pixel_index;
	logic [3:0] phase_count;
	logic frame_end;
	logic pixel_end;
	logic running;

	// Pixel path
	logic [1:0] pixel_value;
	logic [7:0] colour_byte;
	logic [2:0] luma_base;
	logic [2:0] luma_bcast;
	logic carrier;
	logic [3:0] base_nibble;
	logic [3:0] bcast_nibble;
	logic [7:0] group_byte;
	logic [7:0] next_byte;
	logic [31:0] next_pins;
	logic [31:0] next_oe_n;

	// Zero in a count field means the full span
	function automatic logic [12:0] span_of(input logic [11:0] field, input logic [12:0] full);
		span_of = (field == 12'h000) ? full : {1'b0, field};
	endfunction

	// Luma pushed one step up or down, clipped to the three-bit range
	function automatic logic [2:0] modulate(input logic [7:0] cb, input logic enable,
		input logic [3:0] phase);
		logic [3:0] wave;
		wave = phase + cb[7:4];
		modulate = cb[2:0];
		if (enable && cb[3])
		begin
			if (!wave[3] && cb[2:0] != 3'h7)
				modulate = cb[2:0] + 3'h1;
			else if (wave[3] && cb[2:0] != 3'h0)
				modulate = cb[2:0] - 3'h1;
		end
	endfunction

	assign output_mode_field = video_configuration[CFG_MODE_LSB +: 2];
	assign colour_depth_bit = video_configuration[CFG_DEPTH_BIT];
	assign broadcast_chroma_enable = video_configuration[CFG_BCAST_CHROMA_BIT];
	assign baseband_chroma_enable = video_configuration[CFG_BASE_CHROMA_BIT];
	assign aural_source_select = video_configuration[CFG_AURAL_LSB +: 3];
	assign pin_group_select = video_configuration[CFG_GROUP_LSB +: 3];
	assign pin_output_mask = video_configuration[CFG_MASK_LSB +: 8];
	assign clocks_per_pixel = video_scale[SCL_PIXEL_LSB +: 8];
	assign clocks_per_frame = video_scale[SCL_FRAME_LSB +: 12];

	// Register writes; reserved bits are never stored
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			video_configuration <= CFG_RESET;
			video_scale <= SCL_RESET;
		end
		else
		begin
			if (CONFIG_WRITE)
				video_configuration <= REG_WDATA & CFG_WRITE_MASK;
			if (SCALE_WRITE)
				video_scale <= REG_WDATA & SCL_WRITE_MASK;
		end
	end

	assign CONFIG_RDATA = video_configuration;
	assign SCALE_RDATA = video_scale;

	// Two-flop synchronisers; bit 0 PLL A, bit 1 PLL B, bits 10:3 aural, bit 2 PLL B running
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync_meta <= 11'h000;
			sync_stable <= 11'h000;
			pll_a_prev <= 1'b0;
		end
		else
		begin
			sync_meta <= {AURAL_PLL_CLOCKS, COUNTER_B_RUNNING, COUNTER_B_PLL_CLOCK,
				COUNTER_A_PLL_CLOCK};
			sync_stable <= sync_meta;
			pll_a_prev <= sync_stable[0];
		end
	end

	// Rising edge of PLL A, seen only on stable samples
	assign pll_a_tick = sync_stable[0] && !pll_a_prev;
	assign running = output_mode_field != MODE_OFF;
	assign frame_end = running && pll_a_tick && frame_count == 13'h0001;
	assign pixel_end = pixel_count == 9'h001;

	// Handoff buffer: the core stalls in its wait while all DEPTH entries are full
	assign HANDOFF_READY = fill != CNT_W'(DEPTH);
	assign buffer_push = HANDOFF_VALID && HANDOFF_READY;
	assign buffer_pop = frame_end && fill != '0;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end
		else
		begin
			if (buffer_push)
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (buffer_pop)
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			if (buffer_push && !buffer_pop)
				fill <= fill + 1'b1;
			else if (buffer_pop && !buffer_push)
				fill <= fill - 1'b1;
		end
	end

	// Buffer storage; no reset needed on data
	always_ff @(posedge CLK)
	begin
		if (buffer_push)
			buffer_mem[wr_ptr] <= HANDOFF_DATA;
	end

	// Frame load; an empty buffer falls back to whatever the core buses hold
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			frame <= '0;
			FRAME_STARVED <= 1'b0;
		end
		else
		begin
			FRAME_STARVED <= frame_end && fill == '0;
			if (buffer_pop)
				frame <= buffer_mem[rd_ptr];
			else if (frame_end)
				frame <= CORE_BUS_DATA;
		end
	end

	// Frame and pixel counters on PLL A ticks; held at count one, pixel index zero while the mode is off
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			frame_count <= 13'h0001;
			pixel_count <= 9'h001;
			pixel_index <= 5'h00;
		end
		else if (!running)
		begin
			// Idle: first tick after enabling loads a frame
			frame_count <= 13'h0001;
			pixel_count <= 9'h001;
			pixel_index <= 5'h00;
		end
		else if (pll_a_tick)
		begin
			if (frame_end)
			begin
				frame_count <= span_of(clocks_per_frame, FRAME_ZERO_COUNT);
				pixel_count <= 9'(span_of({4'h0, clocks_per_pixel},
					{4'h0, PIXEL_ZERO_COUNT}));
				pixel_index <= 5'h00;
			end
			else
			begin
				frame_count <= frame_count - 13'h0001;
				if (pixel_end)
				begin
					pixel_count <= 9'(span_of({4'h0, clocks_per_pixel},
						{4'h0, PIXEL_ZERO_COUNT}));
					// Hold the last pixel once the word is used up
					if (pixel_index != (colour_depth_bit ? LAST_IDX_FOUR : LAST_IDX_TWO))
						pixel_index <= pixel_index + 5'h01;
				end
				else
					pixel_count <= pixel_count - 9'h001;
			end
		end
	end

	// Chroma phase advances once per PLL A clock while the mode is not off, sixteen steps per cycle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			phase_count <= 4'h0;
		else if (running && pll_a_tick)
			phase_count <= phase_count + 4'h1;
	end

	// Pixel selection, least significant first
	always_comb
	begin
		if (colour_depth_bit)
			pixel_value = frame.pixels[{pixel_index[3:0], 1'b0} +: 2];
		else
			pixel_value = {1'b0, frame.pixels[pixel_index]};
		colour_byte = frame.colours[{pixel_value, 3'h0} +: 8];
	end

	// Composite modulation of the colour byte
	assign luma_base = modulate(colour_byte, baseband_chroma_enable, phase_count);
	assign luma_bcast = modulate(colour_byte, broadcast_chroma_enable, phase_count);
	assign carrier = sync_stable[1] && sync_stable[2];
	assign base_nibble = {1'b0, luma_base};
	// Broadcast carries the selected aural carrier on its top bit
	assign bcast_nibble = carrier ? {sync_stable[3 + aural_source_select], luma_bcast} : 4'h0;

	// Mode mux, group routing and pin masking
	always_comb
	begin
		case (output_mode_field)
			MODE_PARALLEL: group_byte = colour_byte;
			MODE_COMP_BCAST_HIGH: group_byte = {bcast_nibble, base_nibble};
			MODE_COMP_BCAST_LOW: group_byte = {base_nibble, bcast_nibble};
			default: group_byte = 8'h00;
		endcase
		next_byte = group_byte & pin_output_mask;
		next_pins = 32'h0000_0000;
		next_oe_n = 32'hffff_ffff;
		// Reserved groups and the off mode drive nothing
		if (running && pin_group_select <= GROUP_LAST)
		begin
			next_pins[{pin_group_select[1:0], 3'h0} +: 8] = next_byte;
			next_oe_n[{pin_group_select[1:0], 3'h0} +: 8] = ~pin_output_mask;
		end
	end

	// Pin outputs are registered so they never glitch between pixels
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PIN_OUT <= 32'h0000_0000;
			PIN_OE_N <= 32'hffff_ffff;
		end
		else
		begin
			PIN_OUT <= next_pins;
			PIN_OE_N <= next_oe_n;
		end
	end

endmodule

// >>> cvg_video_generator_sva.sv
`timescale 1ns/1ps
module cvg_video_generator_sva
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CONFIG_WRITE,
	input wire logic SCALE_WRITE,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] CONFIG_RDATA,
	input wire logic [31:0] SCALE_RDATA,
	input wire logic HANDOFF_VALID,
	input wire logic HANDOFF_READY,
	input wire logic FRAME_STARVED,
	input wire logic [31:0] PIN_OUT,
	input wire logic [31:0] PIN_OE_N
);
	import cvg_pkg::*;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	logic [31:0] oe_exp; // Enables the settings ask for
	// Reserved groups and mode off leave every pin released
	always_comb
	begin
		oe_exp = '1;
		if (CONFIG_RDATA[30:29] != MODE_OFF && CONFIG_RDATA[11:9] <= GROUP_LAST)
		begin
			oe_exp[CONFIG_RDATA[10:9] * 8 +: 8] = ~CONFIG_RDATA[7:0];
		end
	end
	// Settings unchanged long enough for the pin stage to follow
	sequence s_cfg_still;
		$stable(CONFIG_RDATA) [*3];
	endsequence
	sequence s_mode_off;
		(CONFIG_RDATA[30:29] == MODE_OFF) [*4];
	endsequence
	a_cfg_echo: assert property (CONFIG_WRITE |=> CONFIG_RDATA == ($past(REG_WDATA) & CFG_WRITE_MASK))
		else $error("configuration readback wrong");
	a_scl_echo: assert property (SCALE_WRITE |=> SCALE_RDATA == ($past(REG_WDATA) & SCL_WRITE_MASK))
		else $error("scale readback wrong");
	a_cfg_holds: assert property (!CONFIG_WRITE |=> $stable(CONFIG_RDATA))
		else $error("configuration changed without write");
	a_oe_follows: assert property (s_cfg_still |-> PIN_OE_N == oe_exp)
		else $error("pin enables disagree with group and mask");
	a_off_silent: assert property (s_mode_off |-> !FRAME_STARVED)
		else $error("frame loaded while mode off");
	a_ready_drop: assert property ($fell(HANDOFF_READY) |-> $past(HANDOFF_VALID))
		else $error("ready fell without a handoff");
	a_starve_empty: assert property (FRAME_STARVED |-> $past(HANDOFF_READY))
		else $error("starved load with frames buffered");
	a_starve_pulse: assert property (FRAME_STARVED |=> !FRAME_STARVED)
		else $error("starved flag longer than one cycle");
	a_pins_gated: assert property ((PIN_OUT & PIN_OE_N) == 32'h0000_0000)
		else $error("pin data present on a released pin");
endmodule
bind cvg_video_generator cvg_video_generator_sva chk_u (.CLK, .RST_N, .CONFIG_WRITE,
	.SCALE_WRITE, .REG_WDATA, .CONFIG_RDATA, .SCALE_RDATA, .HANDOFF_VALID,
	.HANDOFF_READY, .FRAME_STARVED, .PIN_OUT, .PIN_OE_N);

// >>> cvg_video_generator_tb_top.sv
`timescale 1ns/1ps
module cvg_video_generator_tb_top;
	import cvg_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_wr = 1'b0;
	logic scl_wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [31:0] cfg_rd, scl_rd, pin_out, oe_n, oe_x;
	logic valid, ready, starved;
	logic pll_a = 1'b0; // Runs from time zero, before any setup
	cvg_frame_type hdata;
	cvg_frame_type core_bus = '0; // Dark at first, so enabling shows no stale byte
	logic pll_b = 1'b0; // Second PLL clock, held high while the carrier is tested
	logic pll_b_run = 1'b0; // Second PLL running level
	logic [7:0] aural = '0; // Aural carriers of the eight cores
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int starved_n = 0;
	int starved_0 = 0;
	int dt;
	logic [7:0] prev = '0;
	logic [7:0] log_v[$]; // Changes on pin group 1
	int log_t[$];
	logic [15:0] seen;
	logic [7:0] exp_v[7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h11, 8'h22, 8'h55};
	int exp_t[7] = '{8, 8, 8, 8, 88, 40, 160}; // Four system clocks per tick
	always #5 clk = ~clk;
	always #20 pll_a = ~pll_a;
	cvg_video_generator dut_u
	(
		.CLK(clk), .RST_N(rst_n), .CONFIG_WRITE(cfg_wr), .SCALE_WRITE(scl_wr),
		.REG_WDATA(wdata), .CONFIG_RDATA(cfg_rd), .SCALE_RDATA(scl_rd),
		.HANDOFF_VALID(valid), .HANDOFF_READY(ready), .HANDOFF_DATA(hdata),
		.CORE_BUS_DATA(core_bus), .FRAME_STARVED(starved), .COUNTER_A_PLL_CLOCK(pll_a),
		.COUNTER_B_PLL_CLOCK(pll_b), .COUNTER_B_RUNNING(pll_b_run), .AURAL_PLL_CLOCKS(aural),
		.PIN_OUT(pin_out), .PIN_OE_N(oe_n)
	);
	cvg_core_model core_u (.clk(clk), .rst_n(rst_n), .ready(ready), .valid(valid), .data(hdata));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic summarize();
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One write strobe pulse, then room for readback to settle
	task automatic wr(input logic cfg, input logic [31:0] d);
		@(posedge clk);
		cfg_wr <= cfg;
		scl_wr <= !cfg;
		wdata <= d;
		@(posedge clk);
		cfg_wr <= 1'b0;
		scl_wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// Cycle count, change log and hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (starved === 1'b1)
			starved_n++;
		if (pin_out[15:8] !== prev)
		begin
			log_v.push_back(pin_out[15:8]);
			log_t.push_back(cyc);
			prev = pin_out[15:8];
		end
		if (cyc == 6000)
		begin
			failures++;
			summarize();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(cfg_rd, '0);
		chk(oe_n, '1);
		chk(ready, 1);
		wr(1, '1);
		chk(cfg_rd, 32'h7f80_0eff);
		chk(oe_n, '1);
		wr(1, '0);
		// Bus value for the starved load; the frame latched above stays dark
		core_bus <= {32'h0000_0005, 32'h0};
		wr(0, '1);
		chk(scl_rd, 32'h000f_ffff);
		wr(0, 32'h0000_2028);
		core_u.push({32'h4433_2211, 32'h4000_00e4});
		core_u.push({32'h8877_6655, 32'h0});
		repeat (6) @(posedge clk);
		chk(ready, 0);
		log_v.delete();
		log_t.delete();
		starved_0 = starved_n;
		// Four colours, two ticks a pixel, twenty pixels a frame
		wr(1, 32'h3000_02ff);
		repeat (400) @(posedge clk);
		foreach (exp_v[i])
		begin
			dt = log_t[i + 1] - log_t[i];
			chk(log_v[i], exp_v[i]);
			chk(dt >= exp_t[i] - 1 && dt <= exp_t[i] + 1, 1);
		end
		chk(log_v[7], 8'h05);
		chk(starved_n - starved_0, 1);
		for (int m = 0; m < 4; m++)
			for (int g = 0; g < 5; g++)
			begin
				oe_x = '1;
				if (m != 0 && g < 4)
					oe_x[g * 8 +: 8] = 8'hc3;
				wr(1, (m << 29) | (g << 9) | 32'h3c);
				repeat (3) @(posedge clk);
				chk(oe_n, oe_x);
			end
		// Composite: baseband nibble follows luma, no broadcast carrier
		wr(1, 32'h4000_00ff);
		repeat (8) @(posedge clk);
		chk(pin_out[7:0], 8'h05);
		wr(1, 32'h6000_00ff);
		repeat (8) @(posedge clk);
		chk(pin_out[7:0], 8'h50);
		core_bus <= {32'h0000_000d, 32'h0};
		wr(1, 32'h4000_00ff);
		repeat (200) @(posedge clk);
		chk(pin_out[7:0], 8'h05);
		wr(1, 32'h4400_00ff);
		repeat (8) @(posedge clk);
		seen = '0;
		repeat (64)
		begin
			@(posedge clk);
			seen = seen | (16'h1 << pin_out[3:0]);
		end
		chk(seen, 16'h0050);
		chk(pin_out[7:4], 4'h0);
		// Broadcast nibble: a running carrier passes the chosen aural source
		pll_b <= 1'b1;
		pll_b_run <= 1'b1;
		aural <= 8'h04;
		wr(1, 32'h4100_00ff);
		repeat (8) @(posedge clk);
		chk(pin_out[7:0], 8'hd5);
		wr(1, 32'h4180_00ff);
		repeat (8) @(posedge clk);
		chk(pin_out[7:0], 8'h55);
		wr(1, 32'h4900_00ff);
		repeat (8) @(posedge clk);
		seen = '0;
		repeat (64)
		begin
			@(posedge clk);
			seen = seen | (16'h1 << pin_out[7:4]);
		end
		chk(seen, 16'h5000);
		pll_b_run <= 1'b0;
		wr(1, 32'h4100_00ff);
		repeat (8) @(posedge clk);
		chk(pin_out[7:0], 8'h05);
		summarize();
	end
endmodule
